// [logic/hv_input_check.sv]
/*
  Pull selection, buffer enable and input sampling for the four high-voltage
  inputs. Assumes the pad reports each input's digital level on hvPinLevel.
*/
`timescale 1ns/1ns
module hv_input_check (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Control
  input  wire logic       analogModeEnable,
  input  wire logic       dividerBypass,
  input  wire logic [1:0] analogPinSelect,
  input  wire logic       pullSelect,
  input  wire logic       bufferForce,
  input  wire logic       stopMode,
  input  wire logic [3:0] digitalEnable,
  // Pads
  input  wire logic [3:0] hvPinLevel,
  output logic      [3:0] bufferOn,
  output logic      [3:0] pullupOn,
  output logic      [3:0] dividerPulldown,
  // Synchronized state
  output logic      [3:0] hvInputState
);

  logic [3:0] sync1;
  wire  [3:0] selMask;
  wire        forceOk;
  wire  [3:0] next_buffer;
  wire  [3:0] next_pullup;
  wire  [3:0] next_pulldown;

  assign selMask = 4'h1 << analogPinSelect;
  assign forceOk = bufferForce && !dividerBypass;
  // Run mode analog disables the selected buffer to avoid shoot-through, unless bufferForce is set without dividerBypass.
  assign next_buffer = stopMode ? digitalEnable :
                       analogModeEnable ?
                         ((digitalEnable & ~selMask) | (forceOk ? selMask : 4'h0)) :
                         digitalEnable;
  assign next_pullup   = (analogModeEnable && !dividerBypass && pullSelect) ?
                         selMask : 4'h0;
  // The pulldown is the divider leg, so it is requested from the divider.
  assign next_pulldown = (analogModeEnable && !dividerBypass && !pullSelect) ?
                         selMask : 4'h0;

  always_ff @(posedge clk) begin
    if (reset) begin
      bufferOn        <= 4'h0;
      pullupOn        <= 4'h0;
      dividerPulldown <= 4'h0;
      sync1           <= 4'h0;
      hvInputState    <= 4'h0;
    end else begin
      bufferOn        <= next_buffer;
      pullupOn        <= next_pullup;
      dividerPulldown <= next_pulldown;
      sync1           <= hvPinLevel & bufferOn;
      hvInputState    <= sync1;
    end
  end

endmodule

// [logic/port_extras_pkg.sv]
/*
  Constants shared by the port extras block: register offsets, field positions
  and reset values.
  Assumes a 32-bit classic Wishbone slave with word-aligned registers.
*/
package port_extras_pkg;

  localparam logic [7:0] ADDR_MISC   = 8'h00;
  localparam logic [7:0] ADDR_PORTP  = 8'h04;
  localparam logic [7:0] ADDR_FLAG   = 8'h08;
  localparam logic [7:0] ADDR_IRQEN  = 8'h0C;
  localparam logic [7:0] ADDR_ANALOG = 8'h10;
  localparam logic [7:0] ADDR_HVIN   = 8'h14;
  localparam logic [7:0] ADDR_ROUTE  = 8'h18;

  // Misc control fields.
  localparam int MISC_MONITOR = 0;
  localparam int MISC_FULL  = 1;
  // Port P data fields.
  localparam int PORTP_DATA = 0;
  localparam int PORTP_DIR  = 1;
  // Flag and enable fields.
  localparam int FLAG_OC    = 0;
  // Analog control fields.
  localparam int AN_SEL_LO  = 0;
  localparam int AN_SEL_HI  = 1;
  localparam int AN_ENABLE  = 2;
  localparam int AN_DIRECT  = 3;
  localparam int AN_PULL    = 4;
  localparam int AN_FORCE   = 5;
  // Route fields: per trigger, PWM enable, internal use, alternative pin.
  localparam int RT_PWM_EN  = 0;
  localparam int RT_INTERN  = 2;
  localparam int RT_ALT     = 4;

  localparam logic [1:0] MISC_RESET   = 2'h0;
  localparam logic [1:0] PORTP_RESET  = 2'h0;
  localparam logic [5:0] ANALOG_RESET = 6'h00;
  localparam logic [5:0] ROUTE_RESET  = 6'h00;

endpackage

// [logic/port_overcurrent_opencheck_trigger.sv]
/*
  Port extras: ADC trigger routing from the PWM 5-4 pins, over-current
  protection on the switched supply pin, and the open-input check on four
  high-voltage inputs, with a classic Wishbone register slave.
  Assumes all pin inputs are synchronous to clk and the analog over-current
  comparator output is presented on overcurrentDetect.
*/
`timescale 1ns/1ns
module port_overcurrent_opencheck_trigger (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // System state
  input  wire logic        stopMode,
  // PWM sources for channels 4 and 5
  input  wire logic [1:0]  pwmWave,
  input  wire logic [1:0]  primaryPinIn,
  input  wire logic [1:0]  altPinIn,
  output logic      [1:0]  adcExtTriggerInputs,
  // Supply-capable pin
  input  wire logic        supplyPwmEnable,
  input  wire logic        supplyPwmWave,
  input  wire logic        overcurrentDetect,
  output logic             supplyPinOut,
  output logic             supplyPinOe,
  output logic             supplyFullDrive,
  output logic             monitorPowered,
  output logic             overcurrentIrq,
  // High-voltage inputs
  input  wire logic [3:0]  hvDigitalEnable,
  input  wire logic [3:0]  hvPinLevel,
  output logic      [3:0]  hvBufferOn,
  output logic      [3:0]  hvPullupOn,
  output logic      [3:0]  hvDividerPulldown,
  output logic      [1:0]  analogPinSelectOut,
  output logic             analogModeOut
);

  logic [1:0] portMiscControl;
  logic [1:0] portP;
  logic       overcurrentFlag;
  logic       overcurrentIrqEnable;
  logic [5:0] analogControl;
  logic [5:0] routeControl;
  logic [3:0] hvInputStateBit;

  wire        access;
  wire        writeAcc;
  wire        lane0;
  wire        hitMisc;
  wire        hitPortP;
  wire        hitFlag;
  wire        hitIrqEn;
  wire        hitAnalog;
  wire        hitRoute;
  wire        hitHvIn;
  wire        wrMisc;
  wire        wrPortP;
  wire        wrIrqEn;
  wire        wrAnalog;
  wire        wrRoute;
  wire        flagClear;
  wire        driveHigh;
  wire        monitorActive;
  wire        ocEvent;
  wire        next_flag;
  wire        next_pinOut;
  wire [31:0] next_rdata;

  // Bus decode: one-wait-state slave, ack lasts one cycle.
  assign access    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign writeAcc  = access && wb_we_i;
  assign lane0     = wb_sel_i[0];
  assign hitMisc   = wb_adr_i == port_extras_pkg::ADDR_MISC;
  assign hitPortP  = wb_adr_i == port_extras_pkg::ADDR_PORTP;
  assign hitFlag   = wb_adr_i == port_extras_pkg::ADDR_FLAG;
  assign hitIrqEn  = wb_adr_i == port_extras_pkg::ADDR_IRQEN;
  assign hitAnalog = wb_adr_i == port_extras_pkg::ADDR_ANALOG;
  assign hitRoute  = wb_adr_i == port_extras_pkg::ADDR_ROUTE;
  assign hitHvIn   = wb_adr_i == port_extras_pkg::ADDR_HVIN;
  assign wrMisc    = writeAcc && lane0 && hitMisc;
  assign wrPortP   = writeAcc && lane0 && hitPortP;
  assign wrIrqEn   = writeAcc && lane0 && hitIrqEn;
  assign wrAnalog  = writeAcc && lane0 && hitAnalog;
  assign wrRoute   = writeAcc && lane0 && hitRoute;
  // The flag clears by writing one to it.
  assign flagClear = writeAcc && lane0 && hitFlag && wb_dat_i[port_extras_pkg::FLAG_OC];

  assign next_rdata =
    hitMisc   ? {30'h00000000, portMiscControl} :
    hitPortP  ? {30'h00000000, portP} :
    hitFlag   ? {31'h00000000, overcurrentFlag} :
    hitIrqEn  ? {31'h00000000, overcurrentIrqEnable} :
    hitAnalog ? {26'h0000000, analogControl} :
    hitRoute  ? {26'h0000000, routeControl} :
    hitHvIn   ? {28'h0000000, hvInputStateBit} :
    32'h00000000;

  // Supply pin is high from the data bit or from the PWM.
  assign driveHigh = supplyPwmEnable ? supplyPwmWave
                                     : portP[port_extras_pkg::PORTP_DATA];
  // Monitor runs only when powered, at full drive, driven high, outside stop.
  assign monitorActive = portMiscControl[port_extras_pkg::MISC_MONITOR]
                      && portMiscControl[port_extras_pkg::MISC_FULL]
                      && driveHigh
                      && portP[port_extras_pkg::PORTP_DIR]
                      && !stopMode;
  assign ocEvent   = monitorActive && overcurrentDetect;
  // Set wins over a clear in the same cycle.
  assign next_flag = ocEvent || (overcurrentFlag && !flagClear);
  // Forcing low uses the next flag so the driver drops on the same edge that sets the flag.
  assign next_pinOut = driveHigh && !next_flag;

  always_ff @(posedge clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= access;
      wb_dat_o <= access ? next_rdata : 32'h00000000;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      portMiscControl      <= port_extras_pkg::MISC_RESET;
      portP                <= port_extras_pkg::PORTP_RESET;
      overcurrentIrqEnable <= 1'b0;
      analogControl        <= port_extras_pkg::ANALOG_RESET;
      routeControl         <= port_extras_pkg::ROUTE_RESET;
    end else begin
      if (wrMisc) begin
        portMiscControl <= wb_dat_i[1:0];
      end
      if (wrPortP) begin
        portP <= wb_dat_i[1:0];
      end
      if (wrIrqEn) begin
        overcurrentIrqEnable <= wb_dat_i[0];
      end
      if (wrAnalog) begin
        analogControl <= wb_dat_i[5:0];
      end
      if (wrRoute) begin
        routeControl <= wb_dat_i[5:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      overcurrentFlag <= 1'b0;
      overcurrentIrq  <= 1'b0;
      supplyPinOut    <= 1'b0;
      supplyPinOe     <= 1'b0;
      supplyFullDrive <= 1'b0;
      monitorPowered  <= 1'b0;
    end else begin
      overcurrentFlag <= next_flag;
      overcurrentIrq  <= next_flag && overcurrentIrqEnable;
      supplyPinOut    <= next_pinOut;
      supplyPinOe     <= portP[port_extras_pkg::PORTP_DIR];
      // Full drive is dropped in stop; the load cannot be supplied there.
      supplyFullDrive <= portMiscControl[port_extras_pkg::MISC_FULL] && !stopMode;
      monitorPowered  <= portMiscControl[port_extras_pkg::MISC_MONITOR] && !stopMode;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      analogPinSelectOut <= 2'h0;
      analogModeOut      <= 1'b0;
    end else begin
      analogPinSelectOut <=
        analogControl[port_extras_pkg::AN_SEL_HI:port_extras_pkg::AN_SEL_LO];
      analogModeOut      <= analogControl[port_extras_pkg::AN_ENABLE];
    end
  end

  // One route per trigger; trigger 0 follows channel 4, trigger 1 channel 5.
  for (genvar i = 0; i < 2; i++) begin : gen_trig
    trigger_route u_route (
      .clk          (clk),
      .reset        (reset),
      .pwmEnable    (routeControl[port_extras_pkg::RT_PWM_EN + i]),
      .pwmInternal  (routeControl[port_extras_pkg::RT_INTERN + i]),
      .altPin       (routeControl[port_extras_pkg::RT_ALT + i]),
      .pwmWave      (pwmWave[i]),
      .primaryPinIn (primaryPinIn[i]),
      .altPinIn     (altPinIn[i]),
      .trigger      (adcExtTriggerInputs[i])
    );
  end

  hv_input_check u_hv (
    .clk              (clk),
    .reset            (reset),
    .analogModeEnable (analogControl[port_extras_pkg::AN_ENABLE]),
    .dividerBypass    (analogControl[port_extras_pkg::AN_DIRECT]),
    .analogPinSelect  (analogControl[port_extras_pkg::AN_SEL_HI:port_extras_pkg::AN_SEL_LO]),
    .pullSelect       (analogControl[port_extras_pkg::AN_PULL]),
    .bufferForce      (analogControl[port_extras_pkg::AN_FORCE]),
    .stopMode         (stopMode),
    .digitalEnable    (hvDigitalEnable),
    .hvPinLevel       (hvPinLevel),
    .bufferOn         (hvBufferOn),
    .pullupOn         (hvPullupOn),
    .dividerPulldown  (hvDividerPulldown),
    .hvInputState     (hvInputStateBit)
  );

endmodule

// [logic/trigger_route.sv]
/*
  Selects the source of one ADC external trigger from its primary or
  alternative pin and from the PWM waveform or the pin input.
  Assumes all inputs are synchronous to clk.
*/
`timescale 1ns/1ns
module trigger_route (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Configuration
  input  wire logic pwmEnable,
  input  wire logic pwmInternal,
  input  wire logic altPin,
  // Sources
  input  wire logic pwmWave,
  input  wire logic primaryPinIn,
  input  wire logic altPinIn,
  // Trigger to the ADC
  output logic      trigger
);

  wire pinIn;
  wire pwmOnPin;
  wire next_trigger;

  assign pinIn        = altPin ? altPinIn : primaryPinIn;
  assign pwmOnPin     = pwmEnable && !pwmInternal;
  assign next_trigger = pwmOnPin ? pwmWave : pinIn;

  always_ff @(posedge clk) begin
    if (reset) begin
      trigger <= 1'b0;
    end else begin
      trigger <= next_trigger;
    end
  end

endmodule

// [verification/pin_loads.sv]
/*
  Model of the loads at the pins: a switchable short on the supply pin and
  external pull resistors on the four high-voltage inputs.
  Assumes the bench chooses which external parts are fitted.
*/
`timescale 1ns/1ns
module pin_loads (
  // Clock
  input wire logic       clk,
  // Fitted parts
  input wire logic       shortLoad,
  input wire logic [3:0] extPullup,
  input wire logic [3:0] extPulldown,
  // Block side
  input wire logic       supplyPinOut,
  input wire logic       supplyPinOe,
  input wire logic [3:0] hvPullupOn,
  input wire logic [3:0] hvDividerPulldown,
  // Pads
  output logic [3:0]     hvPinLevel,
  output logic           overcurrentDetect
);
  logic [3:0] floatPat = 4'h5;

  // A floating input has no level, so it toggles to expose a read that trusts it.
  always @(posedge clk) floatPat <= ~floatPat;

  // External resistors are stiffer than the internal pulls.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (extPulldown[i]) hvPinLevel[i] = 1'b0;
      else if (extPullup[i]) hvPinLevel[i] = 1'b1;
      else if (hvPullupOn[i]) hvPinLevel[i] = 1'b1;
      else if (hvDividerPulldown[i]) hvPinLevel[i] = 1'b0;
      else hvPinLevel[i] = floatPat[i];
    end
  end

  // Current flows into the short only while the pad drives high.
  assign overcurrentDetect = shortLoad && supplyPinOe && supplyPinOut;
endmodule

// [verification/port_extras_properties.sv]
/*
  Checker for the port extras block: bus handshake, over-current cut-off and pad controls.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ns
module port_extras_properties (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Supply pin
  input wire logic        stopMode,
  input wire logic        overcurrentDetect,
  input wire logic        supplyPinOut,
  input wire logic        supplyPinOe,
  input wire logic        supplyFullDrive,
  input wire logic        monitorPowered,
  input wire logic        overcurrentIrq,
  // Pads
  input wire logic [3:0]  hvDigitalEnable,
  input wire logic [3:0]  hvBufferOn,
  input wire logic [3:0]  hvPullupOn,
  input wire logic [3:0]  hvDividerPulldown,
  input wire logic [1:0]  analogPinSelectOut,
  input wire logic        analogModeOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire logic [3:0] selMask = 4'h1 << analogPinSelectOut;

  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  oc_cutoff_a: assert property (monitorPowered && supplyFullDrive && supplyPinOe &&
    supplyPinOut && overcurrentDetect && !stopMode |=> !supplyPinOut)
    else $error("pin not forced low on over-current");
  flag_hold_a: assert property (overcurrentIrq |-> !supplyPinOut)
    else $error("pin driven while flag set");
  stop_off_a: assert property (stopMode |=> !monitorPowered && !supplyFullDrive)
    else $error("monitor or full drive active in stop");
  pull_sel_a: assert property (|hvPullupOn |-> analogModeOut && hvPullupOn == selMask)
    else $error("pullup on wrong input");
  pull_excl_a: assert property ((hvPullupOn & hvDividerPulldown) == 4'h0)
    else $error("pullup and divider pulldown together");
  buf_unsel_a: assert property (analogModeOut && !stopMode && !$past(stopMode) |->
    (hvBufferOn & ~selMask) == ($past(hvDigitalEnable) & ~selMask))
    else $error("unselected buffer wrong in analog mode");

  cover property (overcurrentIrq);
  cover property (|hvPullupOn);
  cover property (analogModeOut && |hvDividerPulldown);
endmodule

bind port_overcurrent_opencheck_trigger port_extras_properties props (.clk, .reset, .wb_cyc_i,
  .wb_stb_i, .wb_dat_o, .wb_ack_o, .stopMode, .overcurrentDetect, .supplyPinOut, .supplyPinOe,
  .supplyFullDrive, .monitorPowered, .overcurrentIrq, .hvDigitalEnable, .hvBufferOn,
  .hvPullupOn, .hvDividerPulldown, .analogPinSelectOut, .analogModeOut);

// [verification/port_overcurrent_opencheck_trigger_tb.sv]
/*
  Self-checking bench for the port extras block with the pin-load model.
  Assumes the register map and reset values given by the shared package.
*/
`timescale 1ns/1ns
module port_overcurrent_opencheck_trigger_tb;
  logic        clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, stopMode, shortLoad;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, hvDigitalEnable, hvPinLevel, hvBufferOn, hvPullupOn;
  logic [3:0]  hvDividerPulldown, extPullup, extPulldown;
  logic [31:0] wb_dat_i, wb_dat_o, expHv;
  logic [1:0]  pwmWave, primaryPinIn, altPinIn, adcExtTriggerInputs, analogPinSelectOut;
  logic [1:0]  expTrig, sel;
  logic        supplyPwmEnable, supplyPwmWave, overcurrentDetect, supplyPinOut, supplyPinOe;
  logic        supplyFullDrive, monitorPowered, overcurrentIrq, analogModeOut, pull, ext;
  logic [5:0]  route;
  logic [31:0] readQ[$];
  int          failCount = 0;
  int          nChecks = 0;

  port_overcurrent_opencheck_trigger DUT (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .stopMode, .pwmWave, .primaryPinIn,
    .altPinIn, .adcExtTriggerInputs, .supplyPwmEnable, .supplyPwmWave, .overcurrentDetect,
    .supplyPinOut, .supplyPinOe, .supplyFullDrive, .monitorPowered, .overcurrentIrq,
    .hvDigitalEnable, .hvPinLevel, .hvBufferOn, .hvPullupOn, .hvDividerPulldown,
    .analogPinSelectOut, .analogModeOut);
  pin_loads loads (.clk, .shortLoad, .extPullup, .extPulldown, .supplyPinOut, .supplyPinOe,
    .hvPullupOn, .hvDividerPulldown, .hvPinLevel, .overcurrentDetect);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tallyAndFinish();
    $display("checks=%0d mismatches=%0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // The request is held until ack is seen; only the bench timeout bounds the wait.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, adr, 4'hF, dat};
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    readQ.push_back(exp);
    wb(1'b0, adr, 32'h0);
  endtask

  always @(posedge clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (readQ.size() == 0) failCount++;
      else chk(wb_dat_o, readQ.pop_front());
    end
  end

  task automatic ocTry(input logic [1:0] misc, input logic [1:0] portp, input logic pwm,
                       input logic expF, input logic expIrq);
    wb(1'b1, port_extras_pkg::ADDR_MISC, 32'(misc));
    wb(1'b1, port_extras_pkg::ADDR_PORTP, 32'(portp));
    {supplyPwmEnable, supplyPwmWave} <= {pwm, pwm};
    @(posedge clk);
    shortLoad <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(32'({overcurrentIrq, supplyPinOut}), 32'({expIrq, ~expF & (portp[0] | pwm)}));
    shortLoad <= 1'b0;
    rd(port_extras_pkg::ADDR_FLAG, 32'(expF));
    wb(1'b1, port_extras_pkg::ADDR_FLAG, 32'h1);
    #1;
    chk(32'(supplyPinOut), 32'(portp[0] | pwm));
  endtask

  initial begin
    #100000;
    failCount++;
    tallyAndFinish();
  end

  initial begin
    reset = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, stopMode, shortLoad, supplyPwmEnable, supplyPwmWave} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, pwmWave, primaryPinIn, altPinIn} = '0;
    {hvDigitalEnable, extPullup, extPulldown} = '0;
    void'($urandom(32'hB5DB345F));
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    // The eighth offset is unmapped and must read as zero.
    for (int a = 0; a < 8; a++) rd(8'(a * 4), 32'h0);
    chk(32'(monitorPowered), 32'h0);
    for (int k = 0; k < 32; k++) begin
      if (k % 4 == 0) begin
        route = 6'($urandom);
        wb(1'b1, port_extras_pkg::ADDR_ROUTE, {26'h0, route});
      end
      @(posedge clk);
      {pwmWave, primaryPinIn, altPinIn} <= 6'($urandom);
      @(posedge clk);
      #1;
      for (int i = 0; i < 2; i++) begin
        expTrig[i] = (route[i] && !route[2 + i]) ? pwmWave[i]
                   : (route[4 + i] ? altPinIn[i] : primaryPinIn[i]);
      end
      chk(32'(adcExtTriggerInputs), 32'(expTrig));
    end
    wb(1'b1, port_extras_pkg::ADDR_IRQEN, 32'h1);
    ocTry(2'h3, 2'h3, 1'b0, 1'b1, 1'b1);
    ocTry(2'h1, 2'h3, 1'b0, 1'b0, 1'b0);
    ocTry(2'h2, 2'h3, 1'b0, 1'b0, 1'b0);
    ocTry(2'h3, 2'h2, 1'b0, 1'b0, 1'b0);
    ocTry(2'h3, 2'h2, 1'b1, 1'b1, 1'b1);
    wb(1'b1, port_extras_pkg::ADDR_IRQEN, 32'h0);
    ocTry(2'h3, 2'h3, 1'b0, 1'b1, 1'b0);
    {supplyPwmEnable, supplyPwmWave} <= 2'b00;
    wb(1'b1, port_extras_pkg::ADDR_PORTP, 32'h2);
    stopMode <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(32'({monitorPowered, supplyFullDrive}), 32'h0);
    @(posedge clk);
    stopMode <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      {pull, sel} = 3'(k);
      ext = 1'($urandom);
      extPulldown <= (pull && ext) ? 4'h1 << sel : 4'h0;
      extPullup <= (!pull && ext) ? 4'h1 << sel : 4'h0;
      wb(1'b1, port_extras_pkg::ADDR_ANALOG, {26'h0, 1'b1, pull, 2'b01, sel});
      repeat (4) @(posedge clk);
      expHv = 32'(pull ? !ext : ext) << sel;
      rd(port_extras_pkg::ADDR_HVIN, expHv);
    end
    {extPullup, extPulldown, hvDigitalEnable} <= {4'hF, 4'h0, 4'hF};
    wb(1'b1, port_extras_pkg::ADDR_ANALOG, {26'h0, 1'b0, 1'b1, 2'b01, 2'h2});
    repeat (4) @(posedge clk);
    rd(port_extras_pkg::ADDR_HVIN, 32'hB);
    tallyAndFinish();
  end
endmodule
